// file: include/fbs_pkg.sv
package fbs_pkg;

  // Application-layer states, one-hot
  typedef enum logic [3:0] {
    FBS_INIT   = 4'b0001,
    FBS_PREOP  = 4'b0010,
    FBS_SAFEOP = 4'b0100,
    FBS_OP     = 4'b1000
  } fbs_state_e;

  // Mailbox services
  typedef enum logic [1:0] {
    FBS_SVC_READ  = 2'b00,
    FBS_SVC_WRITE = 2'b01,
    FBS_SVC_PDO   = 2'b10,
    FBS_SVC_OTHER = 2'b11
  } fbs_svc_e;

  // Object selector produced by the dictionary decoder
  typedef enum logic [3:0] {
    FBS_OBJ_NONE    = 4'h0,
    FBS_OBJ_COUNT   = 4'h1,
    FBS_OBJ_DEVTYPE = 4'h2,
    FBS_OBJ_IDENT   = 4'h3,
    FBS_OBJ_RXMAP   = 4'h4,
    FBS_OBJ_TXMAP   = 4'h5,
    FBS_OBJ_SM2     = 4'h6,
    FBS_OBJ_SM3     = 4'h7,
    FBS_OBJ_IN      = 4'h8,
    FBS_OBJ_OUT     = 4'h9,
    FBS_OBJ_SERIAL  = 4'hA
  } fbs_obj_e;

  localparam logic [15:0] FBS_IDX_DEV_TYPE   = 16'h1000;
  localparam logic [15:0] FBS_IDX_IDENTITY   = 16'h1018;
  localparam logic [15:0] FBS_IDX_RX_MAP     = 16'h1600;
  localparam logic [15:0] FBS_IDX_TX_MAP     = 16'h1A00;
  localparam logic [15:0] FBS_IDX_SM2_ASSIGN = 16'h1C12;
  localparam logic [15:0] FBS_IDX_SM3_ASSIGN = 16'h1C13;
  localparam logic [15:0] FBS_IDX_INPUTS     = 16'h6000;
  localparam logic [15:0] FBS_IDX_OUTPUTS    = 16'h7000;
  localparam logic [15:0] FBS_IDX_SERIAL     = 16'h8000;

  localparam int          FBS_PD_SUBS      = 32;
  localparam logic [7:0]  FBS_PD_SUB_MAX   = 8'h20;
  localparam logic [7:0]  FBS_ID_SUB_MAX   = 8'h04;
  localparam logic [7:0]  FBS_ONE_SUB      = 8'h01;
  localparam int          FBS_BLK_BYTES    = 8;
  localparam int          FBS_BLK_W        = FBS_BLK_BYTES * 8;

  // Reset values: mapping entries (index, sub-index, bit length), SM2/SM3 assignments, serial settings
  localparam logic [31:0] FBS_RXMAP_RST1   = 32'h7000_0140;
  localparam logic [31:0] FBS_TXMAP_RST1   = 32'h6000_0140;
  localparam logic [31:0] FBS_TXMAP_RST2   = 32'h6000_0240;
  localparam logic [31:0] FBS_TXMAP_RST3   = 32'h6000_0340;
  localparam logic [31:0] FBS_SM2_RST      = 32'h0000_1600;
  localparam logic [31:0] FBS_SM3_RST      = 32'h0000_1A00;
  localparam logic [31:0] FBS_SERIAL_RST   = 32'h0000_0000;

  localparam logic [31:0] FBS_ABORT_NO_OBJ = 32'h0602_0000;
  localparam logic [31:0] FBS_ABORT_NO_SUB = 32'h0609_0011;
  localparam logic [31:0] FBS_ABORT_RO     = 32'h0601_0002;
  localparam logic [31:0] FBS_ABORT_SVC    = 32'h0504_0001;

  typedef struct packed {
    fbs_svc_e    svc;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } fbs_mbx_req_s;

  typedef struct packed {
    logic                 abort;
    logic [31:0]          code;
    logic [FBS_BLK_W-1:0] rdata;
  } fbs_mbx_rsp_s;

  typedef struct packed {
    logic                 valid;
    logic [FBS_BLK_W-1:0] data;
  } fbs_pd_s;

endpackage

// file: logic/fbs_obj_dict.sv
`timescale 1ns/1ps
module fbs_obj_dict
  import fbs_pkg::*;
(
  input  wire logic [15:0] index_i,
  input  wire logic [7:0]  sub_i,
  output fbs_obj_e         obj_o,
  output logic             writable_o,
  output logic [7:0]       count_o
);

  // Sub-index 0 of every object reads its entry count; only 1000 has none
  always_comb begin
    obj_o      = FBS_OBJ_NONE;
    writable_o = 1'b0;
    count_o    = 8'h00;
    case (index_i)
      FBS_IDX_DEV_TYPE: begin
        if (sub_i == 8'h00) obj_o = FBS_OBJ_DEVTYPE;
      end
      FBS_IDX_IDENTITY: begin
        count_o = FBS_ID_SUB_MAX;
        if (sub_i == 8'h00) obj_o = FBS_OBJ_COUNT;
        else if (sub_i <= FBS_ID_SUB_MAX) obj_o = FBS_OBJ_IDENT;
      end
      FBS_IDX_RX_MAP, FBS_IDX_TX_MAP: begin
        count_o = FBS_PD_SUB_MAX;
        if (sub_i == 8'h00) obj_o = FBS_OBJ_COUNT;
        else if (sub_i <= FBS_PD_SUB_MAX) begin
          obj_o      = (index_i == FBS_IDX_RX_MAP) ? FBS_OBJ_RXMAP : FBS_OBJ_TXMAP;
          writable_o = 1'b1;
        end
      end
      FBS_IDX_SM2_ASSIGN, FBS_IDX_SM3_ASSIGN, FBS_IDX_SERIAL: begin
        count_o = FBS_ONE_SUB;
        if (sub_i == 8'h00) obj_o = FBS_OBJ_COUNT;
        else if (sub_i == FBS_ONE_SUB) begin
          writable_o = 1'b1;
          if (index_i == FBS_IDX_SM2_ASSIGN) obj_o = FBS_OBJ_SM2;
          else if (index_i == FBS_IDX_SM3_ASSIGN) obj_o = FBS_OBJ_SM3;
          else obj_o = FBS_OBJ_SERIAL;
        end
      end
      FBS_IDX_INPUTS, FBS_IDX_OUTPUTS: begin
        count_o = FBS_PD_SUB_MAX;
        if (sub_i == 8'h00) obj_o = FBS_OBJ_COUNT;
        else if (sub_i <= FBS_PD_SUB_MAX) obj_o = (index_i == FBS_IDX_INPUTS) ? FBS_OBJ_IN : FBS_OBJ_OUT;
      end
      default: obj_o = FBS_OBJ_NONE;
    endcase
  end

endmodule

// file: logic/fbs_gateway.sv
// Function
// - At startup latch the device-select switch and configure the serial side from it; serial_cfg_o is set only by mailbox writes to 8000.
// - In INIT the gateway initialises itself and answers no master traffic.
// - PRE-OP allows configuration by service-data access only, no cyclic data.
// - SAFE-OP delivers no input process data to the master.
// - SAFE-OP ignores master output data and forwards none to serial device.
// - From PRE-OP onward mailbox service requests are served.
// - Enter OP only after valid master process data is seen; then inputs valid.
// - If outputs cannot be activated stay in SAFE-OP and flag an error.
// - Service-data accesses to the dictionary travel over the mailbox.
// - Process-data transfers requested through the mailbox are rejected.
// - Input process data object has sub-entries of 8 bytes each.
// - Output process data object has sub-entries of 8 bytes each.
// - Receive and transmit mapping objects plus assignments to sync managers 2 and 3.
// - An object holds the serial-port settings.
// - Read-only 32-bit device-type object with a fixed profile code.
// - Identity object: vendor, product, revision, serial number, all read-only.
`timescale 1ns/1ps
module fbs_gateway
  import fbs_pkg::*;
#(
  parameter int          SW_W        = 4,
  parameter logic [31:0] DEVICE_TYPE = 32'h0000_0A5A,  // Arbitrary value
  parameter logic [31:0] VENDOR      = 32'h0000_0ABC,  // Arbitrary value
  parameter logic [31:0] PRODUCT     = 32'h0000_0D11,  // Arbitrary value
  parameter logic [31:0] REVISION    = 32'h0000_0001,  // Arbitrary value
  parameter logic [31:0] SERIAL_NO   = 32'h0000_0001   // Arbitrary value
) (
  input  wire logic            clk_i,
  input  wire logic            reset_i,
  input  wire logic [SW_W-1:0] device_select_switch_i,
  input  wire logic            state_req_valid_i,
  input  wire logic [3:0]      state_req_i,
  input  wire logic            station_addr_we_i,
  input  wire logic [15:0]     station_addr_i,
  input  wire logic            out_activate_ok_i,
  input  wire fbs_pd_s         pd_out_i,
  input  wire fbs_pd_s         serial_rx_i,
  input  wire logic            mbx_req_valid_i,
  input  wire fbs_mbx_req_s    mbx_req_i,
  output fbs_state_e           state_o,
  output logic                 state_err_o,
  output logic [15:0]          station_addr_o,
  output logic [SW_W-1:0]      device_sel_o,
  output logic [31:0]          serial_cfg_o,
  output fbs_pd_s              serial_tx_o,
  output fbs_pd_s              pd_in_o,
  output logic                 mbx_rsp_valid_o,
  output fbs_mbx_rsp_s         mbx_rsp_o
);

  typedef struct packed {
    fbs_state_e                      state;
    logic                            cfg_done;
    logic                            op_pending;
    logic                            err;
    logic [SW_W-1:0]                 dev_sel;
    logic [15:0]                     station_addr;
    logic [FBS_PD_SUBS-1:0][31:0]    rx_map;
    logic [FBS_PD_SUBS-1:0][31:0]    tx_map;
    logic [31:0]                     sm2;
    logic [31:0]                     sm3;
    logic [31:0]                     serial_cfg;
    logic [FBS_BLK_W-1:0]            in_blk;
    logic [FBS_BLK_W-1:0]            out_blk;
    fbs_pd_s                         pd_in;
    fbs_pd_s                         pd_tx;
    logic                            rsp_valid;
    fbs_mbx_rsp_s                    rsp;
  } fbs_gw_s;

  fbs_gw_s    r;
  fbs_gw_s    next_r;
  fbs_obj_e   obj;
  logic       obj_writable;
  logic [7:0] obj_count;
  logic [4:0] sub_sel;
  fbs_state_e req_state;

  fbs_obj_dict u_dict (
    .index_i    (mbx_req_i.index),
    .sub_i      (mbx_req_i.sub),
    .obj_o      (obj),
    .writable_o (obj_writable),
    .count_o    (obj_count)
  );

  assign sub_sel   = 5'(mbx_req_i.sub - 8'h01);
  assign req_state = fbs_state_e'(state_req_i);

  function automatic fbs_gw_s reset_value();
    fbs_gw_s v;
    v            = '0;
    v.state      = FBS_INIT;
    v.rx_map[0]  = FBS_RXMAP_RST1;
    v.tx_map[0]  = FBS_TXMAP_RST1;
    v.tx_map[1]  = FBS_TXMAP_RST2;
    v.tx_map[2]  = FBS_TXMAP_RST3;
    v.sm2        = FBS_SM2_RST;
    v.sm3        = FBS_SM3_RST;
    v.serial_cfg = FBS_SERIAL_RST;
    return v;
  endfunction

  always_comb begin
    next_r           = r;
    next_r.rsp_valid = 1'b0;
    next_r.pd_in     = '0;
    next_r.pd_tx     = '0;

    // The switch is sampled on the first edge after reset release, never under reset
    if (!r.cfg_done) begin
      next_r.dev_sel  = device_select_switch_i;
      next_r.cfg_done = 1'b1;
    end

    if (station_addr_we_i && r.state == FBS_INIT) begin
      next_r.station_addr = station_addr_i;
    end

    // Inputs are captured always but only delivered in OP
    if (serial_rx_i.valid) begin
      next_r.in_blk = serial_rx_i.data;
      if (r.state == FBS_OP) begin
        next_r.pd_in = serial_rx_i;
      end
    end

    // Master outputs are dropped entirely outside OP
    if (pd_out_i.valid && r.state == FBS_OP) begin
      next_r.out_blk = pd_out_i.data;
      next_r.pd_tx   = pd_out_i;
    end

    // Pending OP request confirmed by first valid master block
    if (r.op_pending) begin
      if (!out_activate_ok_i) begin
        next_r.op_pending = 1'b0;
        next_r.err        = 1'b1;
      end else if (pd_out_i.valid) begin
        next_r.op_pending = 1'b0;
        next_r.state      = FBS_OP;
      end
    end

    if (state_req_valid_i) begin
      case (r.state)
        FBS_INIT: begin
          if (req_state == FBS_PREOP && r.cfg_done) begin
            next_r.state = FBS_PREOP;
            next_r.err   = 1'b0;
          end else if (req_state != FBS_INIT) begin
            next_r.err = 1'b1;
          end
        end
        FBS_PREOP: begin
          if (req_state == FBS_SAFEOP || req_state == FBS_INIT) begin
            next_r.state = req_state;
            next_r.err   = 1'b0;
          end else if (req_state != FBS_PREOP) begin
            next_r.err = 1'b1;
          end
        end
        FBS_SAFEOP: begin
          if (req_state == FBS_OP) begin
            if (out_activate_ok_i) begin
              next_r.op_pending = 1'b1;
              next_r.err        = 1'b0;
            end else begin
              next_r.op_pending = 1'b0;
              next_r.err        = 1'b1;
            end
          end else if (req_state == FBS_PREOP || req_state == FBS_INIT) begin
            next_r.state      = req_state;
            next_r.op_pending = 1'b0;
            next_r.err        = 1'b0;
          end else if (req_state != FBS_SAFEOP) begin
            next_r.err = 1'b1;
          end
        end
        FBS_OP: begin
          if (req_state == FBS_SAFEOP || req_state == FBS_PREOP || req_state == FBS_INIT) begin
            next_r.state = req_state;
            next_r.err   = 1'b0;
          end else if (req_state != FBS_OP) begin
            next_r.err = 1'b1;
          end
        end
        default: begin
          next_r.state = FBS_INIT;
        end
      endcase
    end

    // Mailbox: silent in INIT, one answer per request otherwise
    if (mbx_req_valid_i && r.state != FBS_INIT) begin
      next_r.rsp_valid = 1'b1;
      next_r.rsp       = '0;
      if (mbx_req_i.svc != FBS_SVC_READ && mbx_req_i.svc != FBS_SVC_WRITE) begin
        next_r.rsp.abort = 1'b1;
        next_r.rsp.code  = FBS_ABORT_SVC;
      end else if (obj == FBS_OBJ_NONE) begin
        next_r.rsp.abort = 1'b1;
        next_r.rsp.code  = (mbx_req_i.index == FBS_IDX_DEV_TYPE || obj_count != 8'h00) ?
                           FBS_ABORT_NO_SUB : FBS_ABORT_NO_OBJ;
      end else if (mbx_req_i.svc == FBS_SVC_WRITE) begin
        if (!obj_writable) begin
          next_r.rsp.abort = 1'b1;
          next_r.rsp.code  = FBS_ABORT_RO;
        end else begin
          case (obj)
            FBS_OBJ_RXMAP:  next_r.rx_map[sub_sel] = mbx_req_i.wdata;
            FBS_OBJ_TXMAP:  next_r.tx_map[sub_sel] = mbx_req_i.wdata;
            FBS_OBJ_SM2:    next_r.sm2 = mbx_req_i.wdata;
            FBS_OBJ_SM3:    next_r.sm3 = mbx_req_i.wdata;
            FBS_OBJ_SERIAL: next_r.serial_cfg = mbx_req_i.wdata;
            default:        next_r.rsp.abort = 1'b0;
          endcase
        end
      end else begin
        case (obj)
          FBS_OBJ_COUNT:   next_r.rsp.rdata = FBS_BLK_W'(obj_count);
          FBS_OBJ_DEVTYPE: next_r.rsp.rdata = FBS_BLK_W'(DEVICE_TYPE);
          FBS_OBJ_IDENT: begin
            case (mbx_req_i.sub)
              8'h01:   next_r.rsp.rdata = FBS_BLK_W'(VENDOR);
              8'h02:   next_r.rsp.rdata = FBS_BLK_W'(PRODUCT);
              8'h03:   next_r.rsp.rdata = FBS_BLK_W'(REVISION);
              default: next_r.rsp.rdata = FBS_BLK_W'(SERIAL_NO);
            endcase
          end
          FBS_OBJ_RXMAP:  next_r.rsp.rdata = FBS_BLK_W'(r.rx_map[sub_sel]);
          FBS_OBJ_TXMAP:  next_r.rsp.rdata = FBS_BLK_W'(r.tx_map[sub_sel]);
          FBS_OBJ_SM2:    next_r.rsp.rdata = FBS_BLK_W'(r.sm2);
          FBS_OBJ_SM3:    next_r.rsp.rdata = FBS_BLK_W'(r.sm3);
          FBS_OBJ_SERIAL: next_r.rsp.rdata = FBS_BLK_W'(r.serial_cfg);
          // Only sub-entry 1 carries the live block; later sub-entries read zero
          FBS_OBJ_IN:     next_r.rsp.rdata = (sub_sel == 5'd0) ? r.in_blk : '0;
          FBS_OBJ_OUT:    next_r.rsp.rdata = (sub_sel == 5'd0) ? r.out_blk : '0;
          default:        next_r.rsp.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= reset_value();
    end else begin
      r <= next_r;
    end
  end

  assign state_o         = r.state;
  assign state_err_o     = r.err;
  assign station_addr_o  = r.station_addr;
  assign device_sel_o    = r.dev_sel;
  assign serial_cfg_o    = r.serial_cfg;
  assign serial_tx_o     = r.pd_tx;
  assign pd_in_o         = r.pd_in;
  assign mbx_rsp_valid_o = r.rsp_valid;
  assign mbx_rsp_o       = r.rsp;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_mbx_taken;
    mbx_req_valid_i && r.state != FBS_INIT;
  endsequence

  sequence s_op_request;
    state_req_valid_i && r.state == FBS_SAFEOP && req_state == FBS_OP;
  endsequence

  property p_init_silent;
    mbx_req_valid_i && r.state == FBS_INIT |=> !mbx_rsp_valid_o;
  endproperty
  a_init_silent: assert property (p_init_silent) else $error("Mailbox answered in INIT");

  property p_mbx_answer;
    s_mbx_taken |=> mbx_rsp_valid_o;
  endproperty
  a_mbx_answer: assert property (p_mbx_answer) else $error("Mailbox request not answered");

  property p_pdo_abort;
    s_mbx_taken ##0 mbx_req_i.svc == FBS_SVC_PDO |=> mbx_rsp_o.abort && mbx_rsp_o.code == FBS_ABORT_SVC;
  endproperty
  a_pdo_abort: assert property (p_pdo_abort) else $error("Mailbox PDO not rejected");

  property p_tx_only_op;
    serial_tx_o.valid |-> $past(r.state) == FBS_OP && $past(pd_out_i.valid);
  endproperty
  a_tx_only_op: assert property (p_tx_only_op) else $error("Outputs forwarded outside OP");

  property p_in_only_op;
    pd_in_o.valid |-> $past(r.state) == FBS_OP && $past(serial_rx_i.valid);
  endproperty
  a_in_only_op: assert property (p_in_only_op) else $error("Inputs delivered outside OP");

  property p_op_entry;
    $rose(r.state == FBS_OP) |-> $past(pd_out_i.valid) && $past(r.op_pending);
  endproperty
  a_op_entry: assert property (p_op_entry) else $error("OP entered without master data");

  property p_activate_fail;
    s_op_request ##0 !out_activate_ok_i |=> r.state == FBS_SAFEOP && state_err_o [*2];
  endproperty
  a_activate_fail: assert property (p_activate_fail) else $error("Failed activation left SAFE-OP");

  property p_ro_abort;
    s_mbx_taken ##0 mbx_req_i.svc == FBS_SVC_WRITE ##0 mbx_req_i.index == FBS_IDX_DEV_TYPE
      |=> mbx_rsp_o.abort && mbx_rsp_o.code == FBS_ABORT_RO;
  endproperty
  a_ro_abort: assert property (p_ro_abort) else $error("Write to device type not aborted");

  property p_vendor_read;
    s_mbx_taken ##0 mbx_req_i.svc == FBS_SVC_READ ##0 mbx_req_i.index == FBS_IDX_IDENTITY
      ##0 mbx_req_i.sub == 8'h01 |=> !mbx_rsp_o.abort && mbx_rsp_o.rdata == FBS_BLK_W'(VENDOR);
  endproperty
  a_vendor_read: assert property (p_vendor_read) else $error("Vendor code read wrong");

  property p_unknown_abort;
    s_mbx_taken ##0 mbx_req_i.svc == FBS_SVC_READ ##0 obj == FBS_OBJ_NONE |=> mbx_rsp_o.abort;
  endproperty
  a_unknown_abort: assert property (p_unknown_abort) else $error("Unknown object not aborted");

  property p_switch_latch;
    !r.cfg_done |=> r.cfg_done && device_sel_o == $past(device_select_switch_i);
  endproperty
  a_switch_latch: assert property (p_switch_latch) else $error("Switch not latched");

endmodule

// file: testbench/fbs_master_model.sv
`timescale 1ns/1ps
module fbs_master_model
  import fbs_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          mbx_rsp_valid_i,
  input  wire fbs_mbx_rsp_s  mbx_rsp_i,
  output logic               state_req_valid_o,
  output logic [3:0]         state_req_o,
  output logic               station_addr_we_o,
  output logic [15:0]        station_addr_o,
  output fbs_pd_s            pd_out_o,
  output logic               mbx_req_valid_o,
  output fbs_mbx_req_s       mbx_req_o
);
  initial begin
    state_req_valid_o = 1'b0;
    state_req_o       = 4'h0;
    station_addr_we_o = 1'b0;
    station_addr_o    = 16'h0000;
    pd_out_o          = '0;
    mbx_req_valid_o   = 1'b0;
    mbx_req_o         = '0;
  end

  // The caller picks the step; t_init asks for a jump up from INIT, and t_safe_and_op jumps from OP back to INIT
  task automatic req_state(input logic [3:0] st);
    @(posedge clk_i);
    #1;
    state_req_o       = st;
    state_req_valid_o = 1'b1;
    @(posedge clk_i);
    #1;
    state_req_valid_o = 1'b0;
    state_req_o       = ~st;
  endtask

  // Position-based address: base plus slot
  task automatic set_addr(input logic [15:0] slot);
    @(posedge clk_i);
    #1;
    station_addr_o    = 16'h03E8 + slot;
    station_addr_we_o = 1'b1;
    @(posedge clk_i);
    #1;
    station_addr_we_o = 1'b0;
    station_addr_o    = ~station_addr_o;
  endtask

  // Gap lets the master be slow to produce its first block
  task automatic send_pd(input logic [63:0] d, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    #1;
    pd_out_o = '{valid: 1'b1, data: d};
    @(posedge clk_i);
    #1;
    pd_out_o = '{valid: 1'b0, data: ~d};
  endtask

  task automatic mbx(input fbs_svc_e svc, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, output logic got, output fbs_mbx_rsp_s rsp);
    got = 1'b0;
    rsp = '0;
    @(posedge clk_i);
    #1;
    mbx_req_o       = '{svc: svc, index: idx, sub: sub, wdata: wd};
    mbx_req_valid_o = 1'b1;
    @(posedge clk_i);
    #1;
    mbx_req_valid_o = 1'b0;
    mbx_req_o       = ~mbx_req_o;
    // The answer pulse stands right after the taking edge, so look before waiting
    for (int i = 0; i < 3; i++) begin
      if (!got && mbx_rsp_valid_i === 1'b1) begin
        got = 1'b1;
        rsp = mbx_rsp_i;
      end
      @(posedge clk_i);
      #1;
    end
  endtask
endmodule

// file: testbench/fbs_gateway_bench.sv
`timescale 1ns/1ps
module fbs_gateway_bench
  import fbs_pkg::*;
;
  // Arbitrary identity values
  localparam logic [31:0] DEV_T = 32'h0000_0B0B;
  localparam logic [31:0] VEND  = 32'h0000_0C0C;
  localparam logic [31:0] PROD  = 32'h0000_0D0D;
  localparam logic [31:0] REV   = 32'h0000_0002;
  localparam logic [31:0] SERNO = 32'h0000_0E0E;

  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic [3:0]   sw = 4'h9;
  logic         ok = 1'b1;
  fbs_pd_s      serial_rx = '0;
  logic         srv, sav, mrv, mv;
  logic [3:0]   sr;
  logic [15:0]  sa, station_addr_o;
  fbs_pd_s      pd_out, serial_tx_o, pd_in_o;
  fbs_mbx_req_s mr;
  fbs_mbx_rsp_s mbx_rsp_o;
  fbs_state_e   state_o;
  logic         state_err_o;
  logic [3:0]   device_sel_o;
  logic [31:0]  serial_cfg_o;
  int           bad_count = 0;
  int           comparisons = 0;
  logic         tv, iv;
  logic [63:0]  td, id;

  always #10 clk = ~clk;

  fbs_master_model mst (.clk_i(clk), .mbx_rsp_valid_i(mrv), .mbx_rsp_i(mbx_rsp_o), .state_req_valid_o(srv),
    .state_req_o(sr), .station_addr_we_o(sav), .station_addr_o(sa), .pd_out_o(pd_out),
    .mbx_req_valid_o(mv), .mbx_req_o(mr));

  fbs_gateway #(.DEVICE_TYPE(DEV_T), .VENDOR(VEND), .PRODUCT(PROD), .REVISION(REV), .SERIAL_NO(SERNO)) DUT (
    .clk_i(clk), .reset_i(reset), .device_select_switch_i(sw), .state_req_valid_i(srv), .state_req_i(sr),
    .station_addr_we_i(sav), .station_addr_i(sa), .out_activate_ok_i(ok), .pd_out_i(pd_out),
    .serial_rx_i(serial_rx), .mbx_req_valid_i(mv), .mbx_req_i(mr), .state_o(state_o),
    .state_err_o(state_err_o), .station_addr_o(station_addr_o), .device_sel_o(device_sel_o),
    .serial_cfg_o(serial_cfg_o), .serial_tx_o(serial_tx_o), .pd_in_o(pd_in_o), .mbx_rsp_valid_o(mrv),
    .mbx_rsp_o(mbx_rsp_o));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A bounded wait that ran out ends the run
  task automatic need(input logic g);
    check(g, 1'b1);
    if (g !== 1'b1) final_report();
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [63:0] e);
    logic         g;
    fbs_mbx_rsp_s r;
    mst.mbx(FBS_SVC_READ, i, s, 32'h0000_0000, g, r);
    need(g);
    check(r.abort, 1'b0);
    check(r.rdata, e);
  endtask

  task automatic ab(input fbs_svc_e v, input logic [15:0] i, input logic [7:0] s, input logic [31:0] c);
    logic         g;
    fbs_mbx_rsp_s r;
    mst.mbx(v, i, s, 32'h0000_0000, g, r);
    need(g);
    check(r.abort, 1'b1);
    check(r.code, c);
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    logic         g;
    fbs_mbx_rsp_s r;
    mst.mbx(FBS_SVC_WRITE, i, s, d, g, r);
    need(g);
    check(r.abort, 1'b0);
  endtask

  task automatic step(input logic [3:0] st, input logic [3:0] e, input logic err);
    mst.req_state(st);
    @(posedge clk);
    #1;
    check(state_o, e);
    check(state_err_o, err);
  endtask

  // Master and serial blocks offered in the same cycle, outputs watched for three edges
  task automatic blocks(input logic [63:0] dout, input logic [63:0] drx);
    fork
      mst.send_pd(dout, 0);
      begin
        @(posedge clk);
        #1;
        serial_rx = '{valid: 1'b1, data: drx};
        @(posedge clk);
        #1;
        serial_rx = '{valid: 1'b0, data: ~drx};
      end
    join
    {tv, iv, td, id} = '0;
    // The output pulse stands from the taking edge to the next one
    repeat (3) begin
      if (serial_tx_o.valid === 1'b1) {tv, td} = {1'b1, serial_tx_o.data};
      if (pd_in_o.valid === 1'b1) {iv, id} = {1'b1, pd_in_o.data};
      @(posedge clk);
      #1;
    end
  endtask

  task automatic t_init();
    logic         g;
    fbs_mbx_rsp_s r;
    check(device_sel_o, 4'h9);
    check(state_o, FBS_INIT);
    mst.mbx(FBS_SVC_READ, FBS_IDX_IDENTITY, 8'h01, 32'h0000_0000, g, r);
    check(g, 1'b0);
    step(FBS_SAFEOP, FBS_INIT, 1'b1);
  endtask

  task automatic t_preop();
    mst.set_addr(16'h0001);
    step(FBS_PREOP, FBS_PREOP, 1'b0);
    check(station_addr_o, 16'h03E9);
    blocks(64'h1111_2222_3333_4444, 64'h5555_6666_7777_8888);
    check({tv, iv}, 2'b00);
  endtask

  task automatic t_dict();
    logic [31:0] ids[4] = '{VEND, PROD, REV, SERNO};
    rd(FBS_IDX_DEV_TYPE, 8'h00, DEV_T);
    ab(FBS_SVC_WRITE, FBS_IDX_DEV_TYPE, 8'h00, FBS_ABORT_RO);
    rd(FBS_IDX_IDENTITY, 8'h00, FBS_ID_SUB_MAX);
    for (int i = 0; i < 4; i++) rd(FBS_IDX_IDENTITY, 8'(i + 1), ids[i]);
    ab(FBS_SVC_WRITE, FBS_IDX_IDENTITY, 8'h02, FBS_ABORT_RO);
    ab(FBS_SVC_READ, 16'h2000, 8'h00, FBS_ABORT_NO_OBJ);
    ab(FBS_SVC_READ, FBS_IDX_IDENTITY, 8'h05, FBS_ABORT_NO_SUB);
    ab(FBS_SVC_PDO, FBS_IDX_INPUTS, 8'h01, FBS_ABORT_SVC);
    ab(FBS_SVC_OTHER, FBS_IDX_INPUTS, 8'h01, FBS_ABORT_SVC);
    rd(FBS_IDX_RX_MAP, 8'h01, FBS_RXMAP_RST1);
    rd(FBS_IDX_TX_MAP, 8'h03, FBS_TXMAP_RST3);
    rd(FBS_IDX_SM2_ASSIGN, 8'h01, FBS_SM2_RST);
    rd(FBS_IDX_SM3_ASSIGN, 8'h01, FBS_SM3_RST);
    rd(FBS_IDX_INPUTS, 8'h00, FBS_PD_SUB_MAX);
    rd(FBS_IDX_OUTPUTS, 8'h20, 64'h0);
    ab(FBS_SVC_READ, FBS_IDX_OUTPUTS, 8'h21, FBS_ABORT_NO_SUB);
    check(serial_cfg_o, FBS_SERIAL_RST);
    wr(FBS_IDX_SERIAL, 8'h01, 32'h0001_C200);
    check(serial_cfg_o, 32'h0001_C200);
    rd(FBS_IDX_SERIAL, 8'h01, 64'h0001_C200);
    wr(FBS_IDX_TX_MAP, 8'h04, 32'h6000_0440);
    rd(FBS_IDX_TX_MAP, 8'h04, 64'h6000_0440);
    ab(FBS_SVC_WRITE, FBS_IDX_RX_MAP, 8'h00, FBS_ABORT_RO);
  endtask

  task automatic t_safe_and_op();
    step(FBS_SAFEOP, FBS_SAFEOP, 1'b0);
    blocks(64'hA5A5_0001_A5A5_0002, 64'h3C3C_0003_3C3C_0004);
    check(tv, 1'b0);
    check(iv, 1'b0);
    rd(FBS_IDX_INPUTS, 8'h01, 64'h3C3C_0003_3C3C_0004);
    ok = 1'b0;
    step(FBS_OP, FBS_SAFEOP, 1'b1);
    ok = 1'b1;
    step(FBS_OP, FBS_SAFEOP, 1'b0);
    mst.send_pd(64'h0F0F_1234_0F0F_5678, 2);
    @(posedge clk);
    #1;
    check(state_o, FBS_OP);
    blocks(64'hDEAD_0001_BEEF_0002, 64'hCAFE_0003_F00D_0004);
    check({tv, td}, {1'b1, 64'hDEAD_0001_BEEF_0002});
    check({iv, id}, {1'b1, 64'hCAFE_0003_F00D_0004});
    rd(FBS_IDX_OUTPUTS, 8'h01, 64'hDEAD_0001_BEEF_0002);
    step(FBS_INIT, FBS_INIT, 1'b0);
  endtask

  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clk);
    t_init();
    t_preop();
    t_dict();
    t_safe_and_op();
    final_report();
  end
endmodule
